// ### pal_array.sv
// Purpose: Fused AND-OR array with ten output macrocells and a fuse program/readback port.
// Assumes: Device clock, inputs, pins and preload pin are asynchronous to clk.
// Notes:   Array behaviour lags the pins by the synchroniser depth.
//
// The plain strobed port and the register offsets were left to the implementer.
`default_nettype none

module pal_array
	import pal_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  dev_clk_pin,
	input  wire logic [PAL_NDIN-1:0]   din,
	input  wire logic [PAL_NOUT-1:0]   io_in,
	output logic      [PAL_NOUT-1:0]   io_out,
	output logic      [PAL_NOUT-1:0]   io_oe,
	input  wire logic                  preload_pin,
	input  wire logic [PAL_ADDR_W-1:0] fuse_addr,
	input  wire logic [PAL_DATA_W-1:0] fuse_wdata,
	input  wire logic                  fuse_wr,
	input  wire logic                  fuse_rd,
	output logic      [PAL_DATA_W-1:0] fuse_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Fuse store
	logic [PAL_NCOL-1:0]  term_fuse [PAL_NTERM];
	logic [PAL_CFG_W-1:0] cfg_fuse;

	// Synchronised pins
	logic [PAL_NDIN-1:0] din_s;
	logic [PAL_NOUT-1:0] io_s;
	logic                dev_clk_s;
	logic                preload_s;
	logic                dev_clk_d;
	logic                clk_rise;

	// Array signals
	logic [PAL_NOUT-1:0]  fb;
	logic [PAL_NLIT-1:0]  lits;
	logic [PAL_NCOL-1:0]  cols;
	logic [PAL_NTERM-1:0] term;
	logic [PAL_NOUT-1:0]  sum;
	logic [PAL_NOUT-1:0]  oe_term;
	logic                 set_term;
	logic                 reset_term;

	// Decoded configuration
	logic [PAL_NOUT-1:0] fb_mode;
	logic [PAL_NOUT-1:0] pol;
	logic                secured;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// All device-side pins pass two flip-flops
	pal_sync #(
		.W (PAL_NDIN + PAL_NOUT + 2)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   ({preload_pin, dev_clk_pin, io_in, din}),
		.level ({preload_s, dev_clk_s, io_s, din_s})
	);

	// Device clock rise becomes a one-cycle enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_clk_d <= 1'b0;
		end else begin
			dev_clk_d <= dev_clk_s;
		end
	end

	assign clk_rise = dev_clk_s & ~dev_clk_d;

	////////////////////////////////////////////////////////////////////////
	// Fuse programming

	// Term fuses only ever blow; a written 1 holds until reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int t = 0; t < PAL_NTERM; t++) begin
				term_fuse[t] <= PAL_TERM_RST;
			end
		end else if (fuse_wr && (fuse_addr < PAL_CFG_ADDR)) begin
			term_fuse[fuse_addr] <= term_fuse[fuse_addr] | fuse_wdata;
		end
	end

	// Select, polarity and security fuses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_fuse <= PAL_CFG_RST;
		end else if (fuse_wr && (fuse_addr == PAL_CFG_ADDR)) begin
			cfg_fuse <= cfg_fuse | fuse_wdata[PAL_CFG_W-1:0];
		end
	end

	// Unblown fuse reads as 0
	assign fb_mode = cfg_fuse[PAL_FB_LSB +: PAL_NOUT];
	assign pol     = cfg_fuse[PAL_POL_LSB +: PAL_NOUT];
	assign secured = cfg_fuse[PAL_SEC_BIT];

	////////////////////////////////////////////////////////////////////////
	// Fuse readback

	// Data stands one cycle after the read strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_rdata <= PAL_ZERO_WORD;
		end else if (!fuse_rd) begin
			fuse_rdata <= PAL_ZERO_WORD;
		end else if (secured && (fuse_addr <= PAL_CFG_ADDR)) begin
			fuse_rdata <= PAL_OPEN_WORD;
		end else if (fuse_addr < PAL_CFG_ADDR) begin
			fuse_rdata <= term_fuse[fuse_addr];
		end else if (fuse_addr == PAL_CFG_ADDR) begin
			fuse_rdata <= {{(PAL_DATA_W - PAL_CFG_W){1'b0}}, cfg_fuse};
		end else begin
			fuse_rdata <= PAL_ZERO_WORD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array inputs

	// Clock pin, eleven inputs and ten feedbacks
	assign lits = {fb, din_s, dev_clk_s};

	// True and complement columns
	assign cols = {~lits, lits};

	////////////////////////////////////////////////////////////////////////
	// Product terms

	// A blown fuse drops its column; an intact pair forces the term low
	always_comb begin
		for (int t = 0; t < PAL_NTERM; t++) begin
			term[t] = &(cols | term_fuse[t]);
		end
	end

	// Shared set and reset terms
	assign reset_term = term[PAL_RESET_TERM];
	assign set_term   = term[PAL_SET_TERM];

	////////////////////////////////////////////////////////////////////////
	// Sum and enable terms per output

	// Each output ORs its own fixed slice of terms
	always_comb begin
		for (int i = 0; i < PAL_NOUT; i++) begin
			sum[i]     = 1'b0;
			oe_term[i] = term[pal_oe_term(i)];
			for (int k = 0; k < PAL_MAXPT; k++) begin
				if (k < PAL_TERM_CNT[i]) begin
					sum[i] = sum[i] | term[pal_oe_term(i) + 1 + k];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Macrocells

	// One cell per output, all on the same clock enable
	for (genvar g = 0; g < PAL_NOUT; g++) begin : g_cell
		pal_mcell u_cell (
			.clk                  (clk),
			.rst_n                (rst_n),
			.clk_rise             (clk_rise),
			.preload              (preload_s),
			.sum                  (sum[g]),
			.oe_term              (oe_term[g]),
			.set_term             (set_term),
			.reset_term           (reset_term),
			.pin_in               (io_s[g]),
			.feedback_mode_fuse   (fb_mode[g]),
			.output_polarity_fuse (pol[g]),
			.pin_out              (io_out[g]),
			.pin_oe               (io_oe[g]),
			.feedback             (fb[g])
		);
	end

endmodule

`default_nettype wire

// ### pal_array_monitor.sv
// Purpose: Port checker for the macrocell array.
// Assumes: Fuse port and pin latencies as handed over.
// Notes:   Shadows the config word only.
`default_nettype none
module pal_array_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        dev_clk_pin,
	input wire logic [10:0] din,
	input wire logic [9:0]  io_in,
	input wire logic [9:0]  io_out,
	input wire logic [9:0]  io_oe,
	input wire logic        preload_pin,
	input wire logic [7:0]  fuse_addr,
	input wire logic [43:0] fuse_wdata,
	input wire logic        fuse_wr,
	input wire logic        fuse_rd,
	input wire logic [43:0] fuse_rdata
);
////////////////
	logic [20:0] cfg;
	logic        blank;
	logic [3:0]  quiet;
	// Config shadow; blank until a term fuse is blown or preload_pin is seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg   <= '0;
			blank <= 1'b1;
		end else begin
			if (fuse_wr && fuse_addr == 8'h84) cfg <= cfg | fuse_wdata[20:0];
			if (preload_pin || (fuse_wr && fuse_addr < 8'h84 && |fuse_wdata)) blank <= 1'b0;
		end
	end
	// Cycles with every pin input unchanged and no fuse write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) quiet <= '0;
		else if (fuse_wr || !$stable({din, io_in, dev_clk_pin, preload_pin})) quiet <= '0;
		else if (quiet != 4'hf) quiet <= quiet + 4'h1;
	end
////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	rd_idle_a:
		assert property (!$past(fuse_rd) |-> fuse_rdata == '0) else $error("stray read data");
	hi_addr_a:
		assert property ($past(fuse_rd) && $past(fuse_addr) > 8'h84 |-> fuse_rdata == '0)
		else $error("high address read");
	cfg_read_a:
		assert property ($past(fuse_rd) && $past(fuse_addr) == 8'h84 && !$past(cfg[20])
			|-> fuse_rdata[20:0] == $past(cfg)) else $error("config readback");
	secure_read_a:
		assert property ($past(fuse_rd) && $past(fuse_addr) <= 8'h84 && $past(cfg[20])
			|-> fuse_rdata == '1) else $error("secured readback");
	preload_oe_a:
		assert property (preload_pin [*3] |-> io_oe == '0) else $error("driven in preload");
	pwrup_a:
		assert property ($rose(rst_n) |-> io_out == '1 && io_oe == '0) else $error("power-up");
	blank_out_a:
		assert property (blank |-> io_oe == '0 && io_out == ~cfg[19:10])
		else $error("blank array level");
	quiet_hold_a:
		assert property (quiet > 4'h5 |-> $stable(io_out) && $stable(io_oe))
		else $error("output moved");
	// Main scenarios
	cover property (preload_pin [*3]);
	cover property ($past(fuse_rd) && $past(cfg[20]));
	cover property ($rose(dev_clk_pin) ##4 io_oe == '1);
endmodule
bind pal_array pal_array_monitor mon (.clk, .rst_n, .dev_clk_pin, .din, .io_in, .io_out,
	.io_oe, .preload_pin, .fuse_addr, .fuse_wdata, .fuse_wr, .fuse_rd, .fuse_rdata);
`default_nettype wire

// ### pal_array_tb.sv
// Purpose: Self-checking bench for the macrocell array.
// Assumes: Fixed-seed shift register for data.
// Notes:   Cell i sums din[i%8]; din[8] sets, din[9] resets.
`default_nettype none
module pal_array_tb import pal_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, rst_n = 1'b0, fuse_wr = 1'b0, fuse_rd = 1'b0;
	logic [10:0] din = '0;
	logic [7:0]  fuse_addr = '0;
	logic [43:0] fuse_wdata = '0, fuse_rdata;
	logic [31:0] rnd = 32'h54f6;
	int          errors = 0, tests_run = 0;
	logic        dev_clk_pin, preload_pin;
	logic [9:0]  io_in, io_out, io_oe, fb, pol, prev;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	pal_array dut (.clk, .rst_n, .dev_clk_pin, .din, .io_in, .io_out, .io_oe, .preload_pin,
		.fuse_addr, .fuse_wdata, .fuse_wr, .fuse_rd, .fuse_rdata);
	pal_sys_model sys (.clk, .io_out, .io_oe, .io_in, .dev_clk_pin, .preload_pin);
////////////////
	// Next random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Cell i shows din[i%8] through its polarity
	function automatic logic [9:0] exp_out(input logic [10:0] d);
		logic [9:0] e;
		for (int i = 0; i < 10; i++) e[i] = d[i % 8] ~^ pol[i];
		return e;
	endfunction
	// Last sum term of cell i
	function automatic logic [7:0] last_term(input int i);
		int b;
		b = 0;
		for (int k = 0; k <= i; k++) b += PAL_TERM_CNT[k] + 1;
		return 8'(b);
	endfunction
	// Compare and count
	task automatic chk(input logic [43:0] g, input logic [43:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Fuse write, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [43:0] d);
		fuse_wr <= 1'b1;
		fuse_addr <= a;
		fuse_wdata <= d;
		@(posedge clk);
		fuse_wr <= 1'b0;
		@(posedge clk);
	endtask
	// Fuse read, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [43:0] e);
		fuse_rd <= 1'b1;
		fuse_addr <= a;
		@(posedge clk);
		fuse_rd <= 1'b0;
		#1 chk(fuse_rdata, e);
		@(posedge clk);
	endtask
	// Verdict
	task automatic complete_run();
		$display("compares %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
////////////////
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(8'h05, '0);
		rd(8'h90, '0);
		rnd = lfsr(rnd);
		fb = {rnd[9:4], 4'b1100};
		pol = {rnd[19:14], 4'b1010};
		wr(8'h84, {24'h0, pol, fb});
		rd(8'h84, {24'h0, pol, fb});
		chk(44'(io_out), {34'h0, ~pol});
		for (int i = 0; i < 10; i++) begin
			wr(last_term(i) - 8'(PAL_TERM_CNT[i]), '1);
			wr(last_term(i), ~(44'h1 << (1 + i % 8)));
		end
		wr(8'd131, ~(44'h1 << 9));
		wr(8'd0, ~(44'h1 << 10));
		$display("fuse test done");
		prev = exp_out('0);
		for (int n = 0; n < 6; n++) begin
			rnd = lfsr(rnd);
			din <= (n == 0) ? 11'h0ff : {3'b000, rnd[7:0]};
			repeat (6) @(posedge clk);
			chk(44'(io_oe), 44'h3ff);
			chk(44'((exp_out(din) & fb) | (prev & ~fb)), 44'(io_out));
			sys.pulse();
			prev = exp_out(din);
			chk(44'(io_out), 44'(prev));
		end
		$display("data test done");
		din <= 11'h100;
		sys.pulse();
		chk(44'(io_out & ~fb), 44'(pol & ~fb));
		din <= 11'h200;
		repeat (6) @(posedge clk);
		chk(44'(io_out & ~fb), {34'h0, ~pol & ~fb});
		din <= 11'h000;
		rnd = lfsr(rnd);
		sys.preload(rnd[9:0]);
		chk(44'(io_out & ~fb), 44'(rnd[9:0] & ~fb));
		// Cell 0 adds register of cell 1; cell 1 adds pin level of combinational cell 2
		wr(8'd2, ~(44'h1 << 13));
		wr(8'd11, ~(44'h1 << 14));
		sys.pulse();
		chk(44'(io_out[1:0]), {42'h0, 1'b1, ~rnd[1]});
		wr(8'h84, 44'h000_0010_0000);
		rd(8'h05, '1);
		rd(8'h84, '1);
		$display("set reset preload secure test done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(44'(io_out), 44'h3ff);
		rd(8'h84, '0);
		$display("reset test done");
		complete_run();
	end
endmodule
`default_nettype wire

// ### pal_mcell.sv
// Purpose: One output macrocell: register, polarity, output enable and feedback select.
// Assumes: clk_rise is a one-cycle pulse per device clock rise; inputs are synchronised.
// Notes:   Registered feedback uses the raw register so the reset term cannot form a loop.
`default_nettype none

module pal_mcell
	import pal_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clk_rise,
	input  wire logic preload,
	input  wire logic sum,
	input  wire logic oe_term,
	input  wire logic set_term,
	input  wire logic reset_term,
	input  wire logic pin_in,
	input  wire logic feedback_mode_fuse,
	input  wire logic output_polarity_fuse,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      feedback
);

	logic q;
	logic q_eff;
	logic level;

	////////////////////////////////////////////////////////////////////////
	// Output register: reset term first, then preload, set, sum
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= PAL_REG_RST;
		end else if (reset_term) begin
			q <= 1'b0;
		end else if (clk_rise) begin
			if (preload) begin
				q <= output_polarity_fuse ? pin_in : ~pin_in;
			end else if (set_term) begin
				q <= 1'b1;
			end else begin
				q <= sum;
			end
		end
	end

	// Reset term masks the register without waiting for a clock
	assign q_eff = q & ~reset_term;

	// Pin level through polarity; combinational cells pass the sum
	assign level   = feedback_mode_fuse ? sum : q_eff;
	assign pin_out = output_polarity_fuse ? level : ~level;
	assign pin_oe  = oe_term & ~preload;

	// Feedback select
	assign feedback = feedback_mode_fuse ? pin_in : q;

endmodule

`default_nettype wire

// ### pal_pkg.sv
// Purpose: Shared constants and helpers for the fused sum-of-products macrocell array.
// Assumes: One 40 MHz system clock; the device clock and all device pins arrive asynchronously.
// Notes:   Fuse value 1 means blown (literal disconnected), 0 means intact.
//
// Behaviour
// - Up to 22 array inputs feed the product terms; ten outputs, one per macrocell.
// - Feedback and polarity fuses pick registered or combinational, active low or high.
// - Registered cells feed back flip-flop state; combinational cells feed back pin level.
// - Each pin driver is enabled only while its own enable term is true.
// - Each output sums a fixed count of product terms, from 8 to 16.
// - Set term at 1 loads every output register with 1 on next clock rise.
// - Reset term at 1 forces every output register to 0 at once.
// - One set term and one reset term act on all registers together.
// - Registered pin level after set or reset is register value through polarity.
// - Test preload can load any state into the output registers.
// - Any output pin can serve as an array input, 21x1 through 12x10.
// - Registers clear at power-up; active-low pins then high, active-high pins low.
// - Blown security fuse disables readback; every other fuse then reads as open.
`default_nettype none

package pal_pkg;

	////////////////////////////////////////////////////////////////////////
	// Array dimensions
	localparam int PAL_NDIN  = 11;
	localparam int PAL_NOUT  = 10;
	localparam int PAL_NLIT  = 22;
	localparam int PAL_NCOL  = 44;
	localparam int PAL_NTERM = 132;
	localparam int PAL_MAXPT = 16;
	localparam int PAL_ADDR_W = 8;
	localparam int PAL_DATA_W = 44;

	// Sum terms per output
	localparam int PAL_TERM_CNT [PAL_NOUT] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};

	// Fixed term positions
	localparam int PAL_RESET_TERM = 0;
	localparam int PAL_SET_TERM   = 131;

	////////////////////////////////////////////////////////////////////////
	// Fuse port map
	localparam logic [PAL_ADDR_W-1:0] PAL_CFG_ADDR = 8'h84;
	localparam int PAL_FB_LSB  = 0;
	localparam int PAL_POL_LSB = 10;
	localparam int PAL_SEC_BIT = 20;
	localparam int PAL_CFG_W   = 21;

	// Values after reset and readback words
	localparam logic [PAL_NCOL-1:0]   PAL_TERM_RST = 44'h000_0000_0000;
	localparam logic [PAL_CFG_W-1:0]  PAL_CFG_RST  = 21'h00_0000;
	localparam logic [PAL_DATA_W-1:0] PAL_OPEN_WORD = 44'hfff_ffff_ffff;
	localparam logic [PAL_DATA_W-1:0] PAL_ZERO_WORD = 44'h000_0000_0000;
	localparam logic                  PAL_REG_RST  = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Index of the enable term of output i; its sum terms follow it
	function automatic int pal_oe_term(input int i);
		int base;
		base = PAL_RESET_TERM + 1;
		for (int k = 0; k < PAL_NOUT; k++) begin
			if (k < i) begin
				base = base + PAL_TERM_CNT[k] + 1;
			end
		end
		return base;
	endfunction

endpackage

`default_nettype wire

// ### pal_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
`default_nettype none

module pal_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);

	logic [W-1:0] meta;

	////////////////////////////////////////////////////////////////////////
	// Two flip-flops per bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta  <= '0;
			level <= '0;
		end else begin
			meta  <= pin;
			level <= meta;
		end
	end

endmodule

`default_nettype wire

// ### pal_sys_model.sv
// Purpose: System side: device clock, preload tester, pin level.
// Assumes: Tasks are entered right after a rising clk edge.
// Notes:   A floating pin shows the inverse of the cell level.
`default_nettype none
module pal_sys_model (
	input  wire logic       clk,
	input  wire logic [9:0] io_out,
	input  wire logic [9:0] io_oe,
	output logic      [9:0] io_in,
	output logic            dev_clk_pin,
	output logic            preload_pin
);
	logic [9:0] drive;
	logic       drv_en;
	// Wire level from both drivers
	assign io_in = (io_oe & io_out) | (~io_oe & (drv_en ? drive : ~io_out));
	// Idle at start
	initial begin
		dev_clk_pin = 1'b0;
		preload_pin = 1'b0;
		drv_en = 1'b0;
		drive = '0;
	end
	// Device clock pulse, wide for set-up
	task automatic pulse();
		@(posedge clk) dev_clk_pin <= 1'b1;
		repeat (4) @(posedge clk);
		dev_clk_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Preload with clock low, drive removed first
	task automatic preload(input logic [9:0] v);
		@(posedge clk) preload_pin <= 1'b1;
		repeat (3) @(posedge clk);
		drive <= v;
		drv_en <= 1'b1;
		pulse();
		drv_en <= 1'b0;
		@(posedge clk) preload_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire
